// ### core/mclp_pkg.sv
// Purpose: shared constants and carriers for the latency pipeline
// Assumes: one clock ref_clk, asynchronous active-low reset
// Notes:   all latency figures are memory clock cycles
package mclp_pkg;
    localparam int ADDR_W      = 24;   // word address width
    localparam int DATA_W      = 72;   // data word width
    localparam int SIZE_W      = 3;    // burst size width
    localparam int FIFO_DEPTH  = 32;   // write data buffer depth
    localparam int CTL_LAT_DEF = 2;    // default controller latency
    // controller address/command stage, best case
    localparam int CTL_AC_FULL = 2;
    localparam int CTL_AC_HALF = 4;
    // phy address/command stage
    localparam int PHY_AC_FULL = 1;
    localparam int PHY_AC_HODD = 1;
    localparam int PHY_AC_HEVN = 2;
    // round trip without memory
    localparam int RT_FULL     = 7;
    localparam int RT_HODD     = 12;
    localparam int RT_HEVN     = 13;
    // memory clocks per local clock
    localparam int MEM_PER_LOC_FULL = 1;
    localparam int MEM_PER_LOC_HALF = 2;
    localparam int MAX_STAGES  = 16;   // longest delay line
    localparam int CNT_W       = 8;    // cycle counter width

    // command carried through the pipeline
    typedef struct packed {
        logic              wr;     // write when set, read when clear
        logic [ADDR_W-1:0] addr;   // word address
        logic [SIZE_W-1:0] size;   // burst size
    } mclp_cmd_t;

    // write data word without its command
    typedef struct packed {
        logic [DATA_W-1:0] data;   // write payload
    } mclp_wdat_t;
endpackage : mclp_pkg

// ### core/mclp_fifo.sv
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: single clock, registered read data
// Notes:   full and empty are exact; depth is a power of two
`timescale 1ns/1ps
module mclp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk,   // clock
    input  wire logic             arst_n,    // async reset
    input  wire logic             in_valid,  // producer has a word
    output logic                  in_ready,  // space available
    input  wire logic [WIDTH-1:0] in_data,   // word in
    output logic                  out_valid, // word available
    input  wire logic             out_ready, // consumer takes word
    output logic      [WIDTH-1:0] out_data   // word out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // storage
    logic [AW:0]      wr_ptr;        // write pointer with wrap bit
    logic [AW:0]      rd_ptr;        // read pointer with wrap bit
    logic [WIDTH-1:0] head;          // registered head word
    logic             head_vld;      // head register holds a word
    wire              full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                              (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              empty = (wr_ptr == rd_ptr);
    wire              push  = in_valid && in_ready;
    wire              load  = !empty && (!head_vld || out_ready);

    assign in_ready  = !full;
    assign out_valid = head_vld;
    assign out_data  = head;

    // storage write
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // pointers and head register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            head     <= '0;
            head_vld <= 1'b0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (load) begin
                head     <= mem[rd_ptr[AW-1:0]];
                rd_ptr   <= rd_ptr + 1'b1;
                head_vld <= 1'b1;
            end else if (out_ready) begin
                head_vld <= 1'b0;
            end
        end
    end
endmodule : mclp_fifo

// ### core/mclp_pipe.sv
// Purpose: fixed-latency command and data pipeline of the controller
// Assumes: ref_clk is the local clock; inputs synchronous
// Notes:   delays are set at build time from rate, parity and controller latency
//
// How it works
// (RL1) all latencies counted in memory clock cycles
// (RL2) half rate: local clock is half memory
// (RL3) read latency: request taken to data returned
// (RL4) write latency: request taken to data driven
// (RL5) stage latency: register to next register
// (RL6) controller stage: 2 full, 4 half
// (RL7) phy stage: 1, or 1/2 by parity
// (RL8) round trip: 7 full, 12/13 half
// (RL9) controller latency parameter, default two
// (RL10) master uses size 2, address 0
// (RL11) every stage is a fixed register chain
`timescale 1ns/1ps
module mclp_pipe import mclp_pkg::*; #(
    parameter bit HALF_RATE = 1'b0,        // half rate build
    parameter bit WL_ODD    = 1'b1,        // write latency odd
    parameter int CTL_LAT   = CTL_LAT_DEF  // controller latency
) (
    input  wire logic              ref_clk,        // local clock
    input  wire logic              arst_n,         // async reset
    input  wire logic              usr_read_req,   // read request
    input  wire logic              usr_write_req,  // write request
    input  wire logic [ADDR_W-1:0] usr_addr,       // word address
    input  wire logic [SIZE_W-1:0] usr_size,       // burst size
    input  wire logic [DATA_W-1:0] usr_wdata,      // write data
    output logic                   usr_ready,      // request taken
    output logic      [DATA_W-1:0] usr_rdata,      // read data
    output logic                   usr_rdata_valid,// read data pulse
    output logic                   mem_cmd_valid,  // command to memory
    output logic      [ADDR_W-1:0] mem_addr,       // memory address
    output logic                   mem_we,         // write command
    output logic                   mem_wdata_valid,// write data driven
    output logic      [DATA_W-1:0] mem_wdata,      // write data
    input  wire logic              mem_rdata_valid,// data from memory
    input  wire logic [DATA_W-1:0] mem_rdata,      // memory data
    output logic      [CNT_W-1:0]  rt_cycles       // last round trip
);
    // memory cycles per local cycle [RL1] [RL2]
    localparam int MPL = HALF_RATE ? MEM_PER_LOC_HALF : MEM_PER_LOC_FULL;
    // controller stage in memory cycles, scaled by setting [RL6] [RL9]
    localparam int CTL_MEM = (HALF_RATE ? CTL_AC_HALF : CTL_AC_FULL)
                             * CTL_LAT / CTL_LAT_DEF;
    // phy stage by rate and parity [RL7]
    localparam int PHY_MEM = !HALF_RATE ? PHY_AC_FULL :
                             (WL_ODD ? PHY_AC_HODD : PHY_AC_HEVN);
    // round trip without memory [RL8]
    localparam int RT_MEM  = !HALF_RATE ? RT_FULL :
                             (WL_ODD ? RT_HODD : RT_HEVN);
    // local-clock stage depths, at least one register each [RL5]
    localparam int CTL_D = (CTL_MEM + MPL - 1) / MPL < 1 ? 1 :
                           (CTL_MEM + MPL - 1) / MPL;
    localparam int PHY_D = (PHY_MEM + MPL - 1) / MPL;
    localparam int RET_MEM = RT_MEM - CTL_MEM - PHY_MEM;
    localparam int RET_D = (RET_MEM + MPL - 1) / MPL < 1 ? 1 :
                           (RET_MEM + MPL - 1) / MPL;
    localparam int CMD_W = $bits(mclp_cmd_t);

    // accepted request
    mclp_cmd_t  acc_cmd;                  // request as captured
    logic       acc_vld;                  // request captured
    logic       fifo_in_ready;            // write buffer has room
    logic       wd_valid;                 // buffered write word ready
    logic [DATA_W-1:0] wd_data;           // buffered write word
    logic       wd_pop;                   // word leaves with its command
    wire        take = usr_ready && (usr_read_req || usr_write_req);

    // stall reads and writes when the write buffer is full
    assign usr_ready = fifo_in_ready;

    // capture register, first register of controller stage [RL3] [RL4]
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_cmd <= '0;
            acc_vld <= 1'b0;
        end else begin
            acc_vld      <= take;
            acc_cmd.wr   <= usr_write_req;
            acc_cmd.addr <= usr_addr;
            acc_cmd.size <= usr_size;
        end
    end

    // write data buffer
    mclp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wfifo (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (take && usr_write_req),
        .in_ready  (fifo_in_ready),
        .in_data   (usr_wdata),
        .out_valid (wd_valid),
        .out_ready (wd_pop),
        .out_data  (wd_data)
    );

    // controller and phy delay lines [RL11]
    logic [CMD_W:0] ctl_sr [CTL_D];       // controller stage chain
    logic [CMD_W:0] phy_sr [PHY_D + 1];   // phy stage chain
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < CTL_D; i++) ctl_sr[i] <= '0;
            for (int i = 0; i <= PHY_D; i++) phy_sr[i] <= '0;
        end else begin
            ctl_sr[0] <= {acc_vld, acc_cmd};          // [RL6]
            for (int i = 1; i < CTL_D; i++) ctl_sr[i] <= ctl_sr[i-1];
            phy_sr[0] <= ctl_sr[CTL_D-1];             // [RL7]
            for (int i = 1; i <= PHY_D; i++) phy_sr[i] <= phy_sr[i-1];
        end
    end

    mclp_cmd_t out_cmd;                   // command leaving the phy
    wire       out_vld = phy_sr[PHY_D][CMD_W];
    assign out_cmd = mclp_cmd_t'(phy_sr[PHY_D][CMD_W-1:0]);
    // pop on the edge that registers the word, so the next write
    // command sees the next word and not the same one again [RL4]
    assign wd_pop  = out_vld && out_cmd.wr;

    // memory command and write data registers [RL4]
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_cmd_valid   <= 1'b0;
            mem_addr        <= '0;
            mem_we          <= 1'b0;
            mem_wdata_valid <= 1'b0;
            mem_wdata       <= '0;
        end else begin
            mem_cmd_valid   <= out_vld;
            mem_addr        <= out_cmd.addr;
            mem_we          <= out_vld && out_cmd.wr;
            mem_wdata_valid <= out_vld && out_cmd.wr && wd_valid;
            mem_wdata       <= wd_data;
        end
    end

    // read return chain [RL3] [RL8]
    logic [DATA_W:0] ret_sr [RET_D];      // read return registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < RET_D; i++) ret_sr[i] <= '0;
        end else begin
            ret_sr[0] <= {mem_rdata_valid, mem_rdata};
            for (int i = 1; i < RET_D; i++) ret_sr[i] <= ret_sr[i-1];
        end
    end
    assign usr_rdata_valid = ret_sr[RET_D-1][DATA_W];
    assign usr_rdata       = ret_sr[RET_D-1][DATA_W-1:0];

    // round-trip counter, memory cycles, first read outstanding
    logic [CNT_W-1:0] rt_run;             // running count
    logic             rt_busy;            // read outstanding
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rt_run    <= '0;
            rt_busy   <= 1'b0;
            rt_cycles <= '0;
        end else if (take && usr_read_req && !rt_busy) begin
            rt_run  <= '0;
            rt_busy <= 1'b1;
        end else if (rt_busy && usr_rdata_valid) begin
            rt_busy   <= 1'b0;
            rt_cycles <= rt_run;                      // [RL1]
        end else if (rt_busy) begin
            rt_run <= rt_run + CNT_W'(MPL);
        end
    end

    // command reaches memory a fixed time after capture
    cmd_fixed_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        acc_vld |-> ##(CTL_D + PHY_D + 2) mem_cmd_valid)
        else $error("command delay wrong"); // [RL11]
    // write data strobe only with a write command
    wr_data_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        mem_wdata_valid |-> mem_we)
        else $error("write data without write"); // [RL4]
    // no request taken while buffer full
    full_stall_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !fifo_in_ready |-> !take)
        else $error("request taken when full"); // [RL3]
    // read return delay fixed
    ret_fixed_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        mem_rdata_valid |-> ##RET_D usr_rdata_valid)
        else $error("read return delay wrong"); // [RL8]
    // round-trip count stable until next read
    rt_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !rt_busy && !$past(rt_busy) |-> $stable(rt_cycles))
        else $error("round trip changed idle"); // [RL5]
    // stage chain moves the valid bit one step a cycle
    ctl_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        acc_vld |=> ctl_sr[0][CMD_W])
        else $error("controller stage missed"); // [RL6]
    // phy stage entered one cycle after controller exit
    phy_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctl_sr[CTL_D-1][CMD_W] |=> phy_sr[0][CMD_W])
        else $error("phy stage missed"); // [RL7]
    // read command not flagged as write
    rd_cmd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        take && usr_read_req && !usr_write_req
        |-> ##(CTL_D + PHY_D + 3) !mem_we)
        else $error("read became write"); // [RL2]

    // read word returned unchanged
    rd_data_a: assert property (@(posedge ref_clk) // [RL3]
        disable iff (!arst_n)
        mem_rdata_valid |->
        ##RET_D (usr_rdata == $past(mem_rdata, RET_D)))
        else $error("read data altered");

    // write command always carries a command strobe
    we_cmd_a: assert property (@(posedge ref_clk) // [RL4]
        disable iff (!arst_n)
        mem_we |-> mem_cmd_valid)
        else $error("write without command");

    // write data driven a fixed time after take
    wdat_lat_a: assert property (@(posedge ref_clk) // [RL4]
        disable iff (!arst_n)
        take && usr_write_req |->
        ##(CTL_D + PHY_D + 3) mem_wdata_valid)
        else $error("write data late");

    // phy exit reaches the memory register next cycle
    phy_out_a: assert property (@(posedge ref_clk) // [RL7]
        disable iff (!arst_n)
        phy_sr[PHY_D][CMD_W] |=> mem_cmd_valid)
        else $error("phy exit lost");

    // controller chain has a fixed depth
    ctl_chain_a: assert property (@(posedge ref_clk) // [RL11]
        disable iff (!arst_n)
        ctl_sr[0][CMD_W] |->
        ##(CTL_D - 1) ctl_sr[CTL_D-1][CMD_W])
        else $error("controller chain length");

    // phy chain has a fixed depth
    phy_chain_a: assert property (@(posedge ref_clk) // [RL11]
        disable iff (!arst_n)
        phy_sr[0][CMD_W] |->
        ##PHY_D phy_sr[PHY_D][CMD_W])
        else $error("phy chain length");

    // address reaches memory unchanged
    addr_keep_a: assert property (@(posedge ref_clk) // [RL3]
        disable iff (!arst_n)
        take |-> ##(CTL_D + PHY_D + 3)
        (mem_addr == $past(usr_addr, CTL_D + PHY_D + 3)))
        else $error("address altered");

    // taken request lands in the capture register
    acc_take_a: assert property (@(posedge ref_clk) // [RL5]
        disable iff (!arst_n)
        take |=> acc_vld)
        else $error("capture missed");

    // round trip count starts from zero
    rt_zero_a: assert property (@(posedge ref_clk) // [RL1]
        disable iff (!arst_n)
        take && usr_read_req && !rt_busy |=> (rt_run == '0))
        else $error("round trip not cleared");

    // round trip count steps in memory cycles
    rt_step_a: assert property (@(posedge ref_clk) // [RL1]
        disable iff (!arst_n)
        rt_busy && !usr_rdata_valid |=>
        (rt_run == $past(rt_run) + CNT_W'(MPL)))
        else $error("round trip step wrong");

    // read command brings no write data
    rd_nodat_a: assert property (@(posedge ref_clk) // [RL4]
        disable iff (!arst_n)
        mem_cmd_valid && !mem_we |-> !mem_wdata_valid)
        else $error("data on read command");

    // buffered word present when its write command leaves
    wd_avail_a: assert property (@(posedge ref_clk) // [RL4]
        disable iff (!arst_n)
        wd_pop |-> wd_valid)
        else $error("write word missing");

    // start of each read return pulse reaches the user RET_D cycles later
    rd_pulse_a: assert property (@(posedge ref_clk) // [RL3]
        disable iff (!arst_n)
        mem_rdata_valid && !$past(mem_rdata_valid) |->
        ##RET_D usr_rdata_valid)
        else $error("read pulse lost");

    // write buffer pops only with a write command
    wd_pop_a: assert property (@(posedge ref_clk) // [RL4]
        disable iff (!arst_n)
        wd_pop |=> mem_we)
        else $error("write word popped alone");
endmodule : mclp_pipe

// ### dv/mclp_mem_model.sv
// Purpose: behavioural memory device behind the pipeline
// Assumes: one command per cycle, fixed read latency from lat
// Notes:   idle read data inverts every cycle, so the last word repeats on every second idle cycle
`timescale 1ns/1ps
module mclp_mem_model import mclp_pkg::*; (
    input  wire logic              ref_clk,         // local clock
    input  wire logic              arst_n,          // async reset
    input  wire logic              mem_cmd_valid,   // command strobe
    input  wire logic [ADDR_W-1:0] mem_addr,        // word address
    input  wire logic              mem_we,          // write command
    input  wire logic              mem_wdata_valid, // write data strobe
    input  wire logic [DATA_W-1:0] mem_wdata,       // write data
    input  wire logic [3:0]        lat,             // read latency
    output logic                   mem_rdata_valid, // read data strobe
    output logic      [DATA_W-1:0] mem_rdata        // read data
);
    logic [DATA_W-1:0] store [logic [ADDR_W-1:0]]; // memory array
    int                due_q [$];                  // return cycles
    logic [DATA_W-1:0] dat_q [$];                  // pending words
    int                cnt;                        // edge counter
    // store writes, return reads lat edges after the command
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt = 0;
            due_q.delete();
            dat_q.delete();
            mem_rdata_valid <= 1'b0;
            mem_rdata       <= '0;
        end else begin
            if (mem_cmd_valid && mem_we && mem_wdata_valid) begin
                store[mem_addr] = mem_wdata;
            end
            if (mem_cmd_valid && !mem_we) begin
                due_q.push_back(cnt + int'(lat) - 1);
                dat_q.push_back(store.exists(mem_addr) ?
                                store[mem_addr] : {DATA_W{1'b1}});
            end
            if (due_q.size() > 0 && due_q[0] == cnt) begin
                void'(due_q.pop_front());
                mem_rdata_valid <= 1'b1;
                mem_rdata       <= dat_q.pop_front();
            end else begin
                // released bus: inverse of last value
                mem_rdata_valid <= 1'b0;
                mem_rdata       <= ~mem_rdata;
            end
            cnt++;
        end
    end
endmodule : mclp_mem_model

// ### dv/mclp_pipe_tb.sv
// Purpose: self-checking bench for the latency pipeline
// Assumes: full rate build, default controller latency
// Notes:   expectations built from package latency figures
`timescale 1ns/1ps
module mclp_pipe_tb import mclp_pkg::*; ;
    localparam int CMD_LAT = CTL_AC_FULL + PHY_AC_FULL + 2; // take to cmd
    localparam int RET_LAT = RT_FULL - CTL_AC_FULL - PHY_AC_FULL;
    typedef struct {
        int t; logic wr; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;
    } mclp_exp_t;
    logic ref_clk, arst_n, usr_read_req, usr_write_req, usr_ready;
    logic [ADDR_W-1:0] usr_addr, mem_addr;
    logic [SIZE_W-1:0] usr_size;
    logic [DATA_W-1:0] usr_wdata, usr_rdata, mem_wdata, mem_rdata;
    logic usr_rdata_valid, mem_cmd_valid, mem_we, mem_wdata_valid;
    logic mem_rdata_valid;
    logic [3:0] mem_lat;                        // memory read latency
    logic [CNT_W-1:0] rt_cycles;                // measured round trip
    int miscompares, tests_run, cyc;
    mclp_exp_t cq [$], rq [$], e;               // expected cmds, reads
    logic [DATA_W-1:0] model [logic [ADDR_W-1:0]];

    mclp_pipe uut (.ref_clk(ref_clk), .arst_n(arst_n),
        .usr_read_req(usr_read_req), .usr_write_req(usr_write_req),
        .usr_addr(usr_addr), .usr_size(usr_size), .usr_wdata(usr_wdata),
        .usr_ready(usr_ready), .usr_rdata(usr_rdata),
        .usr_rdata_valid(usr_rdata_valid), .mem_cmd_valid(mem_cmd_valid),
        .mem_addr(mem_addr), .mem_we(mem_we),
        .mem_wdata_valid(mem_wdata_valid), .mem_wdata(mem_wdata),
        .mem_rdata_valid(mem_rdata_valid), .mem_rdata(mem_rdata),
        .rt_cycles(rt_cycles));
    mclp_mem_model mem (.ref_clk(ref_clk), .arst_n(arst_n),
        .mem_cmd_valid(mem_cmd_valid), .mem_addr(mem_addr), .mem_we(mem_we),
        .mem_wdata_valid(mem_wdata_valid), .mem_wdata(mem_wdata),
        .lat(mem_lat), .mem_rdata_valid(mem_rdata_valid),
        .mem_rdata(mem_rdata));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    task check(input string name, input logic [DATA_W-1:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // scoreboard: takes seen at negedge are taken at the next edge
    always @(negedge ref_clk) if (arst_n === 1'b1) begin
        if (usr_ready === 1'b1 && (usr_read_req || usr_write_req)) begin
            e = '{cyc + 1, usr_write_req, usr_addr, usr_wdata};
            cq.push_back(e);
            if (usr_write_req) model[usr_addr] = usr_wdata;
            else begin
                e.d = model[usr_addr];
                e.t = e.t + CMD_LAT + int'(mem_lat) + RET_LAT;
                rq.push_back(e);
            end
        end
        if (mem_cmd_valid === 1'b1) begin
            if (cq.size() == 0) check("cmd_spurious", 1, 0);
            else begin
                e = cq.pop_front();
                check("cmd_lat", cyc - e.t, CMD_LAT);
                check("cmd_we", mem_we, e.wr);
                check("cmd_addr", mem_addr, e.a);
                check("wdata_valid", mem_wdata_valid, e.wr);
                if (e.wr) check("wdata", mem_wdata, e.d);
            end
        end else check("wdata_alone", mem_wdata_valid, 0);
        if (usr_rdata_valid === 1'b1) begin
            if (rq.size() == 0) check("rd_spurious", 1, 0);
            else begin
                e = rq.pop_front();
                check("rd_lat", cyc, e.t);
                check("rdata", usr_rdata, e.d);
            end
        end
    end

    // hold request until a taking edge; next send may follow at once
    task send(input logic w, input logic [ADDR_W-1:0] a,
              input logic [DATA_W-1:0] d);
        usr_write_req <= w;
        usr_read_req  <= !w;
        usr_addr      <= a;
        usr_wdata     <= d;
        usr_size      <= 3'h2;
        do @(negedge ref_clk); while (usr_ready !== 1'b1);
        @(posedge ref_clk);
    endtask : send
    task drain;
        usr_write_req <= 1'b0;
        usr_read_req  <= 1'b0;
        repeat (30) @(posedge ref_clk);
        check("drain", cq.size() + rq.size(), 0);
    endtask : drain

    task write_single;
        send(1'b1, 24'h000000, 72'h0123456789ABCDEF5A);
        drain();
    endtask : write_single
    task write_burst;
        for (int i = 1; i < 9; i++) send(1'b1, 24'(i), {48'hC3C3C3C3C3C3, 24'(i)});
        drain();
    endtask : write_burst
    task read_pair_size;
        mem_lat <= 4'h3;
        send(1'b0, 24'h000000, '0);
        drain();
        check("rt", rt_cycles, CMD_LAT + 3 + RET_LAT);
    endtask : read_pair_size
    task read_slow_back;
        mem_lat <= 4'h8;
        for (int i = 2; i < 6; i++) send(1'b0, 24'(i), '0);
        drain();
    endtask : read_slow_back
    task write_then_read;
        mem_lat <= 4'h5;
        send(1'b1, 24'h0000AA, 72'hFEDCBA987654321099);
        send(1'b0, 24'h0000AA, '0);
        drain();
    endtask : write_then_read

    task complete_run;
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    initial begin
        #(25 * 3000);
        miscompares++;
        complete_run();
    end
    initial begin
        {arst_n, usr_read_req, usr_write_req} = 3'h0;
        usr_addr = '0; usr_size = '0; usr_wdata = '0;
        mem_lat = 4'h3; cyc = 0; miscompares = 0; tests_run = 0;
        repeat (2) @(posedge ref_clk);
        check("reset", {usr_ready, mem_cmd_valid, usr_rdata_valid}, 3'h4);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        write_single();
        write_burst();
        read_pair_size();
        read_slow_back();
        write_then_read();
        complete_run();
    end
endmodule : mclp_pipe_tb
